//--- include/ufc_pkg.sv
// package: register map, field layout and timing of the fifo control block
package ufc_pkg;
    // register byte addresses
    localparam logic [31:0] QCTL_ADDR     = 32'h4000_8008;
    localparam logic [31:0] IRQ_STAT_ADDR = 32'h4000_8040;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'h4000_8044;
    localparam logic [31:0] STATE_ADDR    = 32'h4000_8048;

    // queue_control fields
    localparam int QC_ON_BIT     = 0;
    localparam int QC_RXFL_BIT   = 1;
    localparam int QC_TXFL_BIT   = 2;
    localparam int QC_THR_LSB    = 6;
    localparam int QC_THR_W      = 2;

    // reset values
    localparam logic            ON_RST   = 1'b0;
    localparam logic [1:0]      THR_RST  = 2'h0;
    localparam logic [2:0]      IRQ_RST  = 3'h0;

    // receive fill thresholds in characters
    localparam logic [7:0] THR_CHARS_0 = 8'h01;
    localparam logic [7:0] THR_CHARS_1 = 8'h04;
    localparam logic [7:0] THR_CHARS_2 = 8'h08;
    localparam logic [7:0] THR_CHARS_3 = 8'h0E;

    // interrupt identification codes
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [3:0] IID_RDA  = 4'h4;
    localparam logic [3:0] IID_CTI  = 4'hC;

    // interrupt status bits
    localparam int IRQ_RDA_BIT   = 0;
    localparam int IRQ_CTI_BIT   = 1;
    localparam int IRQ_FLUSH_BIT = 2;
    localparam int IRQ_W         = 3;

    // timing: clock period and one character time (10 bits at 115200 baud)
    localparam int CLK_PERIOD_NS  = 20;
    localparam int CHAR_TIME_NS   = 86806;
    localparam int CHAR_CLKS_DEF  = CHAR_TIME_NS / CLK_PERIOD_NS;
    // time-out length in character times, inside the 3.5 to 4.5 window
    localparam int TOUT_CHARS     = 4;

    typedef struct packed {
        logic rx;
        logic tx;
    } ufc_flush_t;

    typedef struct packed {
        logic [QC_THR_W-1:0] thr;
        logic                on;
    } ufc_ctrl_t;
endpackage : ufc_pkg

//--- logic/ufc_fifo_ctrl.sv
// fifo control register with receive threshold, time-out and interrupt logic
`timescale 1ns/100ps

//
// Summary of operation
// - enable bit turns on both fifos; bits 7:1 taken only with enable set.
// - any change of the enable bit flushes both receive and transmit fifos.
// - writing one to bit one flushes the receive fifo; bit self-clears.
// - writing one to bit two flushes the transmit fifo; bit self-clears.
// - writing zero to a flush bit, with the enable bit unchanged, leaves its own fifo untouched.
// - threshold field 7:6 selects 1, 4, 8 or 14 characters.
// - control register is write-only; all fields reset to zero.
// - data-available interrupt, code 0100, while fill reaches the threshold.
// - time-out when fifo holds data and sees no activity for about four characters.
module ufc_fifo_ctrl #(
    parameter int LEVEL_W   = 5,
    parameter int CHAR_CLKS = ufc_pkg::CHAR_CLKS_DEF
) (
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire logic [31:0]          addr_in,
    input  wire logic [31:0]          wr_data_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    output      logic [31:0]          rd_data_out,
    input  wire logic [LEVEL_W-1:0]   rx_level_in,
    input  wire logic                 rx_activity_in,
    output      ufc_pkg::ufc_flush_t  flush_out,
    output      ufc_pkg::ufc_ctrl_t   ctrl_out,
    output      logic [LEVEL_W-1:0]   rx_fill_threshold_out,
    output      logic                 rda_out,
    output      logic                 cti_out,
    output      logic [3:0]           int_id_out,
    output      logic                 irq_out
);
    import ufc_pkg::*;

    localparam int TOUT_CLKS = TOUT_CHARS * CHAR_CLKS;
    localparam int TOUT_W    = $clog2(TOUT_CLKS + 1);
    localparam logic [TOUT_W-1:0] TOUT_MAX = TOUT_W'(TOUT_CLKS);

    function automatic logic [LEVEL_W-1:0] thr_chars(input logic [1:0] code);
        logic [7:0] n;
        n = THR_CHARS_0;
        unique case (code)
            2'h0: n = THR_CHARS_0;
            2'h1: n = THR_CHARS_1;
            2'h2: n = THR_CHARS_2;
            2'h3: n = THR_CHARS_3;
        endcase
        return LEVEL_W'(n);
    endfunction : thr_chars

    // ---- register state
    ufc_ctrl_t             ctrl_r;
    ufc_ctrl_t             ctrl_nxt;
    ufc_flush_t            flush_r;
    ufc_flush_t            flush_nxt;
    logic [LEVEL_W-1:0]    thr_r;
    logic [TOUT_W-1:0]     idle_r;
    logic [TOUT_W-1:0]     idle_nxt;
    logic                  rda_r;
    logic                  rda_nxt;
    logic                  cti_r;
    logic                  cti_nxt;
    logic [3:0]            iid_r;
    logic [3:0]            iid_nxt;
    logic [IRQ_W-1:0]      stat_r;
    logic [IRQ_W-1:0]      stat_nxt;
    logic [IRQ_W-1:0]      mask_r;
    logic                  irq_r;
    logic [31:0]           rd_data_r;
    logic [31:0]           rd_data_nxt;

    // ---- address decode
    wire logic sel_qctl  = (addr_in == QCTL_ADDR);
    wire logic sel_stat  = (addr_in == IRQ_STAT_ADDR);
    wire logic sel_mask  = (addr_in == IRQ_MASK_ADDR);
    wire logic sel_state = (addr_in == STATE_ADDR);
    wire logic wr_qctl   = wr_in && sel_qctl;
    wire logic wr_stat   = wr_in && sel_stat;
    wire logic wr_mask   = wr_in && sel_mask;

    // ---- control register write
    wire logic new_on     = wr_data_in[QC_ON_BIT];
    wire logic on_change  = wr_qctl && (new_on != ctrl_r.on);
    // upper bits only land when the same write sets the enable bit
    wire logic upper_ok   = wr_qctl && new_on;
    wire logic rx_flush_w = upper_ok && wr_data_in[QC_RXFL_BIT];
    wire logic tx_flush_w = upper_ok && wr_data_in[QC_TXFL_BIT];

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_qctl) begin
            ctrl_nxt.on = new_on;
        end
        if (upper_ok) begin
            ctrl_nxt.thr = wr_data_in[QC_THR_LSB +: QC_THR_W];
        end
    end

    // flush bits are pulses, never stored: they self-clear next cycle
    assign flush_nxt.rx = rx_flush_w || on_change;
    assign flush_nxt.tx = tx_flush_w || on_change;

    // ---- receive threshold and data-available level
    // while disabled the fifo acts as one character deep
    wire logic [LEVEL_W-1:0] thr_nxt = ctrl_nxt.on ? thr_chars(ctrl_nxt.thr)
                                                   : LEVEL_W'(1);
    wire logic flushing   = flush_r.rx;
    wire logic rx_nonzero = (rx_level_in != '0);
    assign rda_nxt = !flush_nxt.rx && (rx_level_in >= thr_nxt);

    // ---- character time-out
    // any push or pop, or an empty or flushed fifo, restarts the idle count
    always_comb begin
        idle_nxt = idle_r;
        if (rx_activity_in || !rx_nonzero || flushing || flush_nxt.rx) begin
            idle_nxt = '0;
        end else if (idle_r != TOUT_MAX) begin
            idle_nxt = idle_r + TOUT_W'(1);
        end
    end
    assign cti_nxt = (idle_nxt == TOUT_MAX);

    // ---- identification, data-available ranks ahead of time-out
    assign iid_nxt = rda_nxt ? IID_RDA : (cti_nxt ? IID_CTI : IID_NONE);

    // ---- sticky status, set wins over a write-one clear
    wire logic [IRQ_W-1:0] stat_set = {flush_nxt.rx || flush_nxt.tx,
                                       cti_nxt && !cti_r,
                                       rda_nxt && !rda_r};
    wire logic [IRQ_W-1:0] stat_clr = wr_stat ? wr_data_in[IRQ_W-1:0] : '0;
    assign stat_nxt = (stat_r & ~stat_clr) | stat_set;
    wire logic [IRQ_W-1:0] mask_nxt = wr_mask ? wr_data_in[IRQ_W-1:0] : mask_r;

    // ---- read mux; control register reads as zero since it is write-only
    wire logic [31:0] state_word = {16'h0000,
                                    {(8 - LEVEL_W){1'b0}}, rx_level_in,
                                    2'h0, iid_r, cti_r, rda_r};
    always_comb begin
        rd_data_nxt = 32'h0000_0000;
        if (rd_in) begin
            if (sel_stat) begin
                rd_data_nxt = {{(32 - IRQ_W){1'b0}}, stat_r};
            end else if (sel_mask) begin
                rd_data_nxt = {{(32 - IRQ_W){1'b0}}, mask_r};
            end else if (sel_state) begin
                rd_data_nxt = state_word;
            end
        end
    end

    // ---- flops
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_r    <= '{thr: THR_RST, on: ON_RST};
            flush_r   <= '{rx: 1'b0, tx: 1'b0};
            thr_r     <= LEVEL_W'(1);
            idle_r    <= '0;
            rda_r     <= 1'b0;
            cti_r     <= 1'b0;
            iid_r     <= IID_NONE;
            stat_r    <= IRQ_RST;
            mask_r    <= IRQ_RST;
            irq_r     <= 1'b0;
            rd_data_r <= 32'h0000_0000;
        end else begin
            ctrl_r    <= ctrl_nxt;
            flush_r   <= flush_nxt;
            thr_r     <= thr_nxt;
            idle_r    <= idle_nxt;
            rda_r     <= rda_nxt;
            cti_r     <= cti_nxt;
            iid_r     <= iid_nxt;
            stat_r    <= stat_nxt;
            mask_r    <= mask_nxt;
            irq_r     <= |(stat_nxt & mask_nxt);
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data_out           = rd_data_r;
    assign flush_out             = flush_r;
    assign ctrl_out              = ctrl_r;
    assign rx_fill_threshold_out = thr_r;
    assign rda_out               = rda_r;
    assign cti_out               = cti_r;
    assign int_id_out            = iid_r;
    assign irq_out               = irq_r;

    // ---- checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_enable_change_flush: assert property (
        wr_qctl && (wr_data_in[0] != ctrl_r.on) |=> flush_out.rx && flush_out.tx)
        else $error("enable change did not flush both fifos");

    chk_disabled_write_ignored: assert property (
        wr_qctl && !wr_data_in[0] && (ctrl_r.on == 1'b0)
        |=> !flush_out.rx && !flush_out.tx && $stable(ctrl_out.thr))
        else $error("upper bits accepted while fifos disabled");

    chk_rx_flush_pulse: assert property (
        wr_qctl && wr_data_in[0] && wr_data_in[1] && ctrl_r.on
        |=> flush_out.rx ##1 !flush_out.rx || $past(wr_in))
        else $error("receive flush missing or not self-clearing");

    chk_tx_flush_pulse: assert property (
        wr_qctl && wr_data_in[0] && wr_data_in[2] && ctrl_r.on
        |=> flush_out.tx)
        else $error("transmit flush missing");

    chk_zero_no_flush: assert property (
        wr_qctl && wr_data_in[0] && ctrl_r.on && !wr_data_in[1] && !wr_data_in[2]
        |=> !flush_out.rx && !flush_out.tx)
        else $error("zero flush bit caused a flush");

    chk_threshold_map: assert property (
        ctrl_out.on |-> rx_fill_threshold_out ==
            (ctrl_out.thr == 2'h0 ? LEVEL_W'(1) : ctrl_out.thr == 2'h1 ? LEVEL_W'(4) :
             ctrl_out.thr == 2'h2 ? LEVEL_W'(8) : LEVEL_W'(14)))
        else $error("threshold encoding mismatch");

    chk_ctrl_reads_zero: assert property (
        rd_in && sel_qctl |=> rd_data_out == 32'h0000_0000)
        else $error("write-only register returned data");

    chk_rda_level: assert property (
        !flush_out.rx && ($past(rx_level_in) >= rx_fill_threshold_out)
        |-> rda_out && int_id_out == 4'h4)
        else $error("data-available not raised at threshold");

    chk_rda_drop: assert property (
        $past(rx_level_in) < rx_fill_threshold_out |-> !rda_out)
        else $error("data-available held below threshold");

    chk_timeout_clear: assert property (
        rx_activity_in |=> !cti_out)
        else $error("time-out survived fifo activity");

    chk_irq_gate: assert property (
        irq_out == |(stat_r & mask_r))
        else $error("interrupt output disagrees with status and mask");

    chk_flush_needs_write: assert property (
        !wr_in |=> !flush_out.rx && !flush_out.tx)
        else $error("flush pulse without a control write");

    chk_rx_zero_no_flush: assert property (
        wr_qctl && wr_data_in[0] && ctrl_r.on && !wr_data_in[1] |=> !flush_out.rx)
        else $error("receive fifo flushed by a zero bit");

    chk_tx_zero_no_flush: assert property (
        wr_qctl && wr_data_in[0] && ctrl_r.on && !wr_data_in[2] |=> !flush_out.tx)
        else $error("transmit fifo flushed by a zero bit");

    chk_enable_follows_write: assert property (
        wr_qctl |=> ctrl_out.on == $past(wr_data_in[0]))
        else $error("enable bit did not follow the write");

    chk_threshold_taken: assert property (
        wr_qctl && wr_data_in[0] |=> ctrl_out.thr == $past(wr_data_in[7:6]))
        else $error("threshold code not taken while enabled");

    chk_ctrl_holds: assert property (
        !wr_qctl |=> $stable(ctrl_out))
        else $error("control changed without a write");

    chk_disabled_one_char: assert property (
        !ctrl_out.on |-> rx_fill_threshold_out == LEVEL_W'(1))
        else $error("threshold not one character while disabled");

    chk_flush_drops_rda: assert property (
        flush_out.rx |-> !rda_out)
        else $error("data-available raised during a receive flush");

    chk_iid_none: assert property (
        !rda_out && !cti_out |-> int_id_out == IID_NONE)
        else $error("identification code set with no source");

    chk_iid_timeout: assert property (
        !rda_out && cti_out |-> int_id_out == 4'hC)
        else $error("time-out identification code wrong");

    chk_timeout_needs_data: assert property (
        cti_out |-> $past(rx_level_in) != '0)
        else $error("time-out raised with an empty fifo");

    chk_rd_idle_zero: assert property (
        !$past(rd_in) |-> rd_data_out == 32'h0000_0000)
        else $error("read data not zero outside a read answer");

    chk_rd_status: assert property (
        rd_in && sel_stat |=> rd_data_out == {{(32 - IRQ_W){1'b0}}, $past(stat_r)})
        else $error("status read returned wrong data");

    chk_rd_mask: assert property (
        rd_in && sel_mask |=> rd_data_out == {{(32 - IRQ_W){1'b0}}, $past(mask_r)})
        else $error("mask read returned wrong data");

    chk_status_set_wins: assert property (
        |stat_set |=> (stat_r & $past(stat_set)) == $past(stat_set))
        else $error("status event lost to a clear");

    chk_status_sticky: assert property (
        !wr_stat |=> (stat_r & $past(stat_r)) == $past(stat_r))
        else $error("status bit cleared without a write");

    chk_status_clear: assert property (
        wr_stat && stat_set == '0 |=> (stat_r & $past(wr_data_in[IRQ_W-1:0])) == '0)
        else $error("write of one did not clear status");

    chk_mask_holds: assert property (
        !wr_mask |=> $stable(mask_r))
        else $error("mask changed without a write");

    // independent quiet-cycle count bounds the time-out window from both sides
    localparam int QW = TOUT_W + 1;
    localparam logic [QW-1:0] QUIET_LO  = QW'((7 * CHAR_CLKS) / 2);
    localparam logic [QW-1:0] QUIET_HI  = QW'((9 * CHAR_CLKS) / 2);
    localparam logic [QW-1:0] QUIET_TOP = QUIET_HI + QW'(1);
    logic [QW-1:0]         quiet_r;
    wire logic quiet_now = rx_nonzero && !rx_activity_in && !flush_out.rx && !flush_nxt.rx;
    wire logic [QW-1:0] quiet_nxt = !quiet_now ? '0
                                  : (quiet_r == QUIET_TOP ? quiet_r : quiet_r + QW'(1));

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            quiet_r <= '0;
        end else begin
            quiet_r <= quiet_nxt;
        end
    end

    chk_timeout_not_early: assert property (
        cti_out |-> quiet_r >= QUIET_LO)
        else $error("time-out earlier than its window");

    chk_timeout_not_late: assert property (
        quiet_r > QUIET_HI |-> cti_out)
        else $error("time-out missing after its window");

    cov_enable_on:  cover property (wr_qctl && wr_data_in[0] && !ctrl_r.on);
    cov_rx_flush:   cover property (flush_out.rx && ctrl_out.on);
    cov_rda_rise:   cover property (!rda_out ##1 rda_out);
    cov_timeout:    cover property (!cti_out ##1 cti_out);
endmodule : ufc_fifo_ctrl

//--- verif/tb.sv
// self-checking testbench of the fifo control register block
`timescale 1ns/100ps
module tb;
    import ufc_pkg::*;
    logic        clk_in, rst_in, wr_in, rd_in, rx_activity_in;
    logic [31:0] addr_in, wr_data_in, rd_data_out, rd_val;
    logic [4:0]  rx_level_in, rx_fill_threshold_out;
    ufc_flush_t  flush_out;
    ufc_ctrl_t   ctrl_out;
    logic        rda_out, cti_out, irq_out;
    logic [3:0]  int_id_out;
    int          fails, num_checks;

    localparam int SIM_CHAR_CLKS = 4;
    localparam int CTI_LO        = (7 * SIM_CHAR_CLKS) / 2;
    localparam int CTI_HI        = (9 * SIM_CHAR_CLKS) / 2;

    // short character time keeps the idle time-out at 16 cycles
    ufc_fifo_ctrl #(.LEVEL_W(5), .CHAR_CLKS(SIM_CHAR_CLKS)) i_ufc_fifo_ctrl (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .rx_level_in(rx_level_in), .rx_activity_in(rx_activity_in),
        .flush_out(flush_out), .ctrl_out(ctrl_out),
        .rx_fill_threshold_out(rx_fill_threshold_out), .rda_out(rda_out),
        .cti_out(cti_out), .int_id_out(int_id_out), .irq_out(irq_out));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1; addr_in <= a; wr_data_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_in);
        rd_in <= 1'b1; addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rd_data_out;
    endtask : rd_reg

    task automatic set_level(input logic [4:0] lv, input logic act);
        @(posedge clk_in);
        rx_level_in <= lv; rx_activity_in <= act;
        @(posedge clk_in);
        rx_activity_in <= 1'b0;
        #1;
    endtask : set_level

    task automatic t_reset;
        chk("ctrl", 32'h0, 32'(ctrl_out));
        chk("threshold", 32'h1, 32'(rx_fill_threshold_out));
        chk("int_id", 32'(IID_NONE), 32'(int_id_out));
        chk("irq", 32'h0, 32'(irq_out));
    endtask : t_reset

    task automatic t_enable;
        wr_reg(QCTL_ADDR, 32'h0000_0043);
        chk("flush on enable", 32'h3, 32'(flush_out));
        chk("ctrl on", 32'h3, 32'(ctrl_out));
        chk("threshold", 32'h4, 32'(rx_fill_threshold_out));
        @(posedge clk_in); #1;
        chk("flush self clear", 32'h0, 32'(flush_out));
        rd_reg(QCTL_ADDR, rd_val);
        chk("control read", 32'h0, rd_val);
        rd_reg(32'h4000_80F0, rd_val);
        chk("unmapped read", 32'h0, rd_val);
    endtask : t_enable

    task automatic t_thresholds;
        logic [7:0] chars [4] = '{THR_CHARS_0, THR_CHARS_1, THR_CHARS_2, THR_CHARS_3};
        for (int k = 0; k < 4; k++) begin
            wr_reg(QCTL_ADDR, 32'(k << 6) | 32'h01);
            chk("threshold code", 32'(chars[k]), 32'(rx_fill_threshold_out));
            chk("no flush", 32'h0, 32'(flush_out));
        end
    endtask : t_thresholds

    task automatic t_flushes;
        wr_reg(QCTL_ADDR, 32'h0000_0005);
        chk("tx flush", 32'h1, 32'(flush_out));
        wr_reg(QCTL_ADDR, 32'h0000_0003);
        chk("rx flush", 32'h2, 32'(flush_out));
        @(posedge clk_in); #1;
        chk("rx self clear", 32'h0, 32'(flush_out));
    endtask : t_flushes

    task automatic t_rda_irq;
        wr_reg(QCTL_ADDR, 32'h0000_0041);
        wr_reg(IRQ_MASK_ADDR, 32'h0000_0001);
        set_level(5'd3, 1'b1);
        chk("rda below", 32'h0, 32'(rda_out));
        set_level(5'd4, 1'b1);
        chk("rda at level", 32'h1, 32'(rda_out));
        chk("int_id rda", 32'(IID_RDA), 32'(int_id_out));
        rd_reg(STATE_ADDR, rd_val);
        chk("state word", 32'h0000_0411, rd_val);
        rd_reg(IRQ_MASK_ADDR, rd_val);
        chk("mask read", 32'h1, rd_val);
        @(posedge clk_in); #1;
        chk("irq raised", 32'h1, 32'(irq_out));
        rd_reg(IRQ_STAT_ADDR, rd_val);
        chk("status rda", 32'h1, rd_val & 32'h1);
        wr_reg(IRQ_STAT_ADDR, 32'h0000_0001);
        @(posedge clk_in); #1;
        chk("irq cleared", 32'h0, 32'(irq_out));
        set_level(5'd3, 1'b1);
        chk("rda withdrawn", 32'h0, 32'(rda_out));
    endtask : t_rda_irq

    task automatic t_timeout;
        int n;
        set_level(5'd3, 1'b1);
        n = 0;
        while (cti_out !== 1'b1) begin
            @(posedge clk_in); #1;
            n++;
            if (n > 40) begin
                fails++;
                give_verdict();
            end
        end
        chk("timeout window", 32'h1, 32'(n >= CTI_LO && n <= CTI_HI));
        chk("int_id cti", 32'(IID_CTI), 32'(int_id_out));
        repeat (4) @(posedge clk_in);
        #1;
        chk("cti stands", 32'h1, 32'(cti_out));
        set_level(5'd3, 1'b1);
        @(posedge clk_in); #1;
        chk("cti cleared", 32'h0, 32'(cti_out));
    endtask : t_timeout

    task automatic t_disable;
        wr_reg(QCTL_ADDR, 32'h0000_00C0);
        chk("flush on disable", 32'h3, 32'(flush_out));
        chk("ctrl off", 32'h0, 32'(ctrl_out.on));
        chk("threshold off", 32'h1, 32'(rx_fill_threshold_out));
        wr_reg(QCTL_ADDR, 32'h0000_00C6);
        chk("disabled write flush", 32'h0, 32'(flush_out));
        chk("disabled write ctrl", 32'h2, 32'(ctrl_out));
    endtask : t_disable

    initial begin
        rst_in = 1'b1; wr_in = 1'b0; rd_in = 1'b0; rx_activity_in = 1'b0;
        addr_in = 32'h0; wr_data_in = 32'h0; rx_level_in = 5'h0;
        fails = 0; num_checks = 0;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        t_reset();
        t_enable();
        t_thresholds();
        t_flushes();
        t_rda_irq();
        t_timeout();
        t_disable();
        give_verdict();
    end
endmodule : tb
